/* File: logic/dci_irq_contrast.sv */
/*
  Display controller interrupt bookkeeping and contrast PWM settings,
  with an AXI4-Lite register slave.
  Writes are answered one cycle after both halves are in; reads one
  cycle after the address is taken.
  Assumes event strobes come from display logic on mclk, and one
  outstanding write and one outstanding read from the bus master.
*/
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module dci_irq_contrast import dci_pkg::*; #(
  parameter int ADDR_W = 32
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dci_evt_t events,
  output logic irq_req,
  output logic contrast_pwm
);

  // Keep only the source bits of a bus word
  function automatic logic [DCI_IRQ_W-1:0] irq_field(input logic [31:0] word);
    irq_field = word[DCI_IRQ_W-1:0] & DCI_IRQ_USED;
  endfunction : irq_field

  // Address matches a register
  // Shared by the write and read decoders
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [31:0] reg_addr);
    hit = (addr == ADDR_W'(reg_addr));
  endfunction : hit

  // Write channel state
  logic awready_q; // Address slot free
  logic awready_d;
  logic wready_q; // Data slot free
  logic wready_d;
  logic aw_held_q; // Address captured
  logic aw_held_d;
  logic w_held_q; // Data captured
  logic w_held_d;
  logic [ADDR_W-1:0] waddr_q; // Captured address
  logic [ADDR_W-1:0] waddr_d;
  logic [31:0] wdata_q; // Captured data
  logic [31:0] wdata_d;
  logic [3:0] wstrb_q; // Captured byte enables
  logic [3:0] wstrb_d;
  logic bvalid_q; // Write answer
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic do_wr; // Both halves present, perform write
  logic wr_known; // Write address maps to a register

  // Read channel state
  logic arready_q; // Read slot free
  logic arready_d;
  logic rvalid_q; // Read answer
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic ar_take; // Read address accepted
  logic rd_known; // Read address maps to a register

  // Block state
  logic [DCI_IRQ_W-1:0] mask_q; // Enabled sources
  logic [DCI_IRQ_W-1:0] mask_d;
  logic [DCI_IRQ_W-1:0] pend_q; // Pending sources
  logic [DCI_IRQ_W-1:0] ev_vec; // Events in register layout
  logic [DCI_IRQ_W-1:0] en_set; // Enable-set write bits
  logic [DCI_IRQ_W-1:0] en_clr; // Enable-clear write bits
  logic [DCI_IRQ_W-1:0] ack; // Acknowledge write bits
  logic irq_q; // Registered request
  logic irq_d;
  // Contrast generator settings
  dci_pwm_cfg_t cfg_q; // Contrast control
  dci_pwm_cfg_t cfg_d;
  logic [DCI_CMP_W-1:0] cmp_q; // Contrast compare value
  logic [DCI_CMP_W-1:0] cmp_d;

  // Write channel: capture address and data in any order, answer after both
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    wr_known = hit(waddr_q, DCI_ADDR_CONTRAST_CTRL) || hit(waddr_q, DCI_ADDR_CONTRAST_CMP) ||
               hit(waddr_q, DCI_ADDR_IRQ_ENABLE_SET) || hit(waddr_q, DCI_ADDR_IRQ_ENABLE_CLEAR) ||
               hit(waddr_q, DCI_ADDR_IRQ_ENABLED_VIEW) || hit(waddr_q, DCI_ADDR_IRQ_PENDING_VIEW) ||
               hit(waddr_q, DCI_ADDR_IRQ_ACKNOWLEDGE);
    do_wr = aw_held_q && w_held_q && !bvalid_q;
    // Address accepted
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    // Data accepted
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    // Write done, raise answer
    if (do_wr) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_known ? DCI_RESP_OKAY : DCI_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Slots reopen only once the answer has been taken
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
  end

  // Read channel: one read in flight, data one cycle after acceptance
  always_comb begin
    ar_take = s_axi_arvalid && arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_known = 1'b1;
    // Decode the address once, on acceptance
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000; // Write-only and reserved bits read zero
      if (hit(s_axi_araddr, DCI_ADDR_CONTRAST_CTRL)) begin
        rdata_d[DCI_CTRL_RUN_BIT:DCI_CTRL_PS_LSB] = cfg_q;
      end else if (hit(s_axi_araddr, DCI_ADDR_CONTRAST_CMP)) begin
        rdata_d[DCI_CMP_W-1:0] = cmp_q;
      end else if (hit(s_axi_araddr, DCI_ADDR_IRQ_ENABLED_VIEW)) begin
        rdata_d[DCI_IRQ_W-1:0] = mask_q;
      end else if (hit(s_axi_araddr, DCI_ADDR_IRQ_PENDING_VIEW)) begin
        rdata_d[DCI_IRQ_W-1:0] = pend_q;
      end else if (hit(s_axi_araddr, DCI_ADDR_IRQ_ENABLE_SET) || hit(s_axi_araddr, DCI_ADDR_IRQ_ENABLE_CLEAR) ||
                   hit(s_axi_araddr, DCI_ADDR_IRQ_ACKNOWLEDGE)) begin
        rdata_d = 32'h0000_0000; // Write-only registers
      end else begin
        rd_known = 1'b0;
      end
      rresp_d = rd_known ? DCI_RESP_OKAY : DCI_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // Next read waits until this answer is taken
    arready_d = !rvalid_d;
  end

  // Register effects of a write, event mapping and request
  always_comb begin
    en_set = '0;
    en_clr = '0;
    ack = '0;
    cfg_d = cfg_q;
    cmp_d = cmp_q;
    // Only byte lane 0 carries defined bits
    if (do_wr && wstrb_q[0]) begin
      if (hit(waddr_q, DCI_ADDR_IRQ_ENABLE_SET)) begin
        en_set = irq_field(wdata_q);
      end
      if (hit(waddr_q, DCI_ADDR_IRQ_ENABLE_CLEAR)) begin
        en_clr = irq_field(wdata_q);
      end
      if (hit(waddr_q, DCI_ADDR_IRQ_ACKNOWLEDGE)) begin
        ack = irq_field(wdata_q);
      end
      if (hit(waddr_q, DCI_ADDR_CONTRAST_CTRL)) begin
        cfg_d = wdata_q[DCI_CTRL_RUN_BIT:DCI_CTRL_PS_LSB];
      end
      if (hit(waddr_q, DCI_ADDR_CONTRAST_CMP)) begin
        cmp_d = wdata_q[DCI_CMP_W-1:0];
      end
    end
    // Zeros leave the mask alone; disable wins if both hit one bit
    mask_d = (mask_q | en_set) & ~en_clr;
    // Events placed in the shared register layout
    ev_vec = '0;
    ev_vec[DCI_BIT_EACH_LINE] = events.each_line;
    ev_vec[DCI_BIT_FINAL_LINE] = events.final_line;
    ev_vec[DCI_BIT_FRAME_DONE] = events.frame_done;
    ev_vec[DCI_BIT_FIFO_STARVE] = events.fifo_starve;
    ev_vec[DCI_BIT_FIFO_OVERFLOW] = events.fifo_overflow;
    ev_vec[DCI_BIT_FETCH_FAULT] = events.fetch_fault;
    // Request from the registered flags, one edge behind them
    irq_d = |(pend_q & mask_q);
  end

  // Sticky pending flags
  dci_event_latch #(
    .WIDTH(DCI_IRQ_W)
  ) u_pending (
    .mclk(mclk),
    .reset(reset),
    .set_i(ev_vec),
    .clr_i(ack),
    .pend_q(pend_q)
  );

  // Contrast generator
  dci_pwm #(
    .CMP_W(DCI_CMP_W)
  ) u_pwm (
    .mclk(mclk),
    .reset(reset),
    .cfg_i(cfg_q),
    .cmp_i(cmp_q),
    .pwm_q(contrast_pwm)
  );

  // Bus registers and the mask, request and contrast settings
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      // Bus handshakes closed in reset
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= DCI_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= DCI_RESP_OKAY;
      // Block state to its reset values
      mask_q <= DCI_MASK_RST;
      irq_q <= 1'b0;
      cfg_q <= '0;
      cmp_q <= DCI_CMP_RST;
    end else begin
      // Bus handshake state
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      // Block state
      mask_q <= mask_d;
      irq_q <= irq_d;
      cfg_q <= cfg_d;
      cmp_q <= cmp_d;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq_req = irq_q;

endmodule : dci_irq_contrast

/* File: logic/dci_pkg.sv */
/*
  Shared constants and types for the display interrupt and contrast block.
  Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package dci_pkg;

  // Register byte addresses
  localparam logic [31:0] DCI_ADDR_CONTRAST_CTRL = 32'h0050_0840;
  localparam logic [31:0] DCI_ADDR_CONTRAST_CMP = 32'h0050_0844;
  localparam logic [31:0] DCI_ADDR_IRQ_ENABLE_SET = 32'h0050_0848;
  localparam logic [31:0] DCI_ADDR_IRQ_ENABLE_CLEAR = 32'h0050_084C;
  localparam logic [31:0] DCI_ADDR_IRQ_ENABLED_VIEW = 32'h0050_0850;
  localparam logic [31:0] DCI_ADDR_IRQ_PENDING_VIEW = 32'h0050_0854;
  localparam logic [31:0] DCI_ADDR_IRQ_ACKNOWLEDGE = 32'h0050_0858;

  // Interrupt source bit positions, shared by every interrupt register
  localparam int DCI_BIT_EACH_LINE = 0;
  localparam int DCI_BIT_FINAL_LINE = 1;
  localparam int DCI_BIT_FRAME_DONE = 2;
  localparam int DCI_BIT_FIFO_STARVE = 4;
  localparam int DCI_BIT_FIFO_OVERFLOW = 5;
  localparam int DCI_BIT_FETCH_FAULT = 6;
  localparam int DCI_IRQ_W = 7;
  // Bits that hold a source; bit 3 is unused
  localparam logic [DCI_IRQ_W-1:0] DCI_IRQ_USED = 7'h77;

  // Contrast control field positions
  localparam int DCI_CTRL_PS_LSB = 0;
  localparam int DCI_CTRL_POL_BIT = 2;
  localparam int DCI_CTRL_RUN_BIT = 3;
  localparam int DCI_CMP_W = 8;

  // Values after reset
  localparam logic [DCI_IRQ_W-1:0] DCI_MASK_RST = 7'h00;
  localparam logic [DCI_IRQ_W-1:0] DCI_PEND_RST = 7'h00;
  localparam logic [DCI_CMP_W-1:0] DCI_CMP_RST = 8'h00;

  // AXI responses
  localparam logic [1:0] DCI_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCI_RESP_SLVERR = 2'h2;

  // Event strobes from the display engine
  typedef struct packed {
    logic fetch_fault;
    logic fifo_overflow;
    logic fifo_starve;
    logic frame_done;
    logic final_line;
    logic each_line;
  } dci_evt_t;

  // Contrast generator settings
  typedef struct packed {
    logic pwm_run;
    logic pulse_polarity;
    logic [1:0] counter_prescale;
  } dci_pwm_cfg_t;

endpackage : dci_pkg

/* File: logic/dci_event_latch.sv */
/*
  Sticky pending flags: one bit per source, set by a hardware event,
  cleared by software. Assumes set and clear come from the same clock.
*/
`timescale 1ns/1ps
module dci_event_latch import dci_pkg::*; #(
  parameter int WIDTH = DCI_IRQ_W
) (
  mclk,
  reset,
  set_i,
  clr_i,
  pend_q
);
  input wire logic mclk; // System clock
  input wire logic reset; // Async, active high
  input wire logic [WIDTH-1:0] set_i; // Event, held high sets the flag
  input wire logic [WIDTH-1:0] clr_i; // Software clear, one cycle
  output logic [WIDTH-1:0] pend_q; // Pending flags

  logic [WIDTH-1:0] pend_d; // Next pending value

  // Set beats clear so no event is lost; flags hold until cleared
  always_comb begin
    pend_d = set_i | (pend_q & ~clr_i);
  end

  // Flag storage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pend_q <= DCI_PEND_RST[WIDTH-1:0];
    end else begin
      pend_q <= pend_d;
    end
  end

endmodule : dci_event_latch

/* File: logic/dci_pwm.sv */
/*
  Contrast PWM: prescaler, free 8-bit counter and compare output.
  Assumes settings come from registers on the same clock.
*/
`timescale 1ns/1ps
module dci_pwm import dci_pkg::*; #(
  parameter int CMP_W = DCI_CMP_W
) (
  mclk,
  reset,
  cfg_i,
  cmp_i,
  pwm_q
);
  input wire logic mclk; // System clock
  input wire logic reset; // Async, active high
  input wire dci_pwm_cfg_t cfg_i; // Run, polarity, prescale
  input wire logic [CMP_W-1:0] cmp_i; // Compare value
  output logic pwm_q; // Contrast output

  logic [2:0] pre_q; // Prescaler count
  logic [2:0] pre_d;
  logic [CMP_W-1:0] cnt_q; // PWM counter
  logic [CMP_W-1:0] cnt_d;
  logic pwm_d;
  logic [2:0] pre_mask; // Prescaler bits that must be all ones
  logic tick; // Counter advance strobe
  logic below; // Counter under compare

  // Counter, prescaler and output next values
  always_comb begin
    unique case (cfg_i.counter_prescale)
      2'h0: pre_mask = 3'h0; // Clock / 1
      2'h1: pre_mask = 3'h1; // Clock / 2
      2'h2: pre_mask = 3'h3; // Clock / 4
      2'h3: pre_mask = 3'h7; // Clock / 8
    endcase
    tick = cfg_i.pwm_run && ((pre_q & pre_mask) == pre_mask);
    pre_d = cfg_i.pwm_run ? 3'(pre_q + 3'h1) : pre_q; // Stopped when off
    cnt_d = tick ? CMP_W'(cnt_q + 1'b1) : cnt_q;
    below = (cnt_q < cmp_i);
    pwm_d = cfg_i.pulse_polarity ? below : ~below;
  end

  // Registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pre_q <= 3'h0;
      cnt_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      pwm_q <= pwm_d;
    end
  end

endmodule : dci_pwm

/* File: bench/dci_irq_contrast_assertions.sv */
/* Port-level checker for the display interrupt and contrast block.
   Assumes it is bound into the block and sees only its top ports. */
`timescale 1ns/1ps
module dci_irq_contrast_chk import dci_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dci_evt_t events,
  input wire logic irq_req,
  input wire logic contrast_pwm
);
  // One clock domain, quiet in reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Answers hold until taken
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  // Read answered one edge after capture
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // No new write while an answer waits
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address open during answer");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("unused read bits set");
  a_err_no_data: assert property (s_axi_rvalid && s_axi_rresp == DCI_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // Request rises only after an event or a register write
  a_irq_cause: assert property ($rose(irq_req) |-> $past(|events, 2) || $past(s_axi_bvalid) ||
    $past(s_axi_bvalid, 2)) else $error("request rose without cause");
  // Request falls only after a register write
  a_irq_sticky: assert property ($fell(irq_req) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("request fell without a write");
  c_irq: cover property ($rose(irq_req));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == DCI_RESP_SLVERR);
  c_pwm: cover property ($rose(contrast_pwm));
endmodule : dci_irq_contrast_chk

bind dci_irq_contrast dci_irq_contrast_chk u_chk (.*);

/* File: bench/dci_engine_model.sv */
/* Display engine stand-in: raises one event source at a time.
   Assumes the caller sits just after a rising mclk edge. */
`timescale 1ns/1ps
module dci_engine_model import dci_pkg::*; (
  input wire logic mclk,
  output dci_evt_t events
);
  // Idle from time zero
  initial events = '0;
  // Hold one source high for len edges, then drop it
  task automatic fire(input int k, input int len);
    @(posedge mclk);
    events <= dci_evt_t'(6'h01 << k);
    repeat (len) @(posedge mclk);
    events <= '0;
  endtask : fire
endmodule : dci_engine_model

/* File: bench/tb_top.sv */
/* Self-checking bench for the display interrupt and contrast block.
   Assumes the AXI4-Lite timing of the block and a 125 MHz clock. */
`timescale 1ns/1ps
module tb_top import dci_pkg::*;;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_req, contrast_pwm;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  wire dci_evt_t events; // Driven by the engine stand-in
  int n_mismatch = 0;
  int tests_run = 0;

  always #4 mclk = ~mclk; // 8 ns period

  dci_irq_contrast dut (.*);
  dci_engine_model eng (.mclk(mclk), .events(events));

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // One comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // One edge, bounded against hangs
  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 5000) begin
      n_mismatch++;
      $display("MISMATCH wait_bound expected response seen none");
      tally_and_finish();
    end
  endtask : tick

  // Bus write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = DCI_RESP_OKAY,
    input logic [3:0] st = 4'hF);
    int n;
    logic ta, tw;
    n = 0;
    ta = 1'h0;
    tw = 1'h0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'h1;
    while (!(ta && tw)) begin
      tick(n);
      if (s_axi_awready && !ta) begin
        s_axi_awvalid <= 1'h0;
        ta = 1'h1;
      end
      if (s_axi_wready && !tw) begin
        s_axi_wvalid <= 1'h0;
        tw = 1'h1;
      end
    end
    // Answer seen first, taken at the next edge: the slave must hold it
    do tick(n); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h1;
    do tick(n); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  // Bus read with expected word and answer code
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e,
    input logic [1:0] er = DCI_RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do tick(n); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    // Answer seen first, taken at the next edge: the slave must hold it
    do tick(n); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h1;
    do tick(n); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(nm, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  // Main sequence
  initial begin
    int pos, n, run, chg;
    logic [31:0] bit_v;
    logic v;
    repeat (20) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    rd("mask_rst", DCI_ADDR_IRQ_ENABLED_VIEW, 32'h0);
    rd("pend_rst", DCI_ADDR_IRQ_PENDING_VIEW, 32'h0);
    wr(DCI_ADDR_IRQ_ENABLE_SET, 32'hFFFF_FFFF);
    rd("mask_all", DCI_ADDR_IRQ_ENABLED_VIEW, 32'h77);
    wr(DCI_ADDR_IRQ_ENABLE_CLEAR, 32'h0000_000D);
    wr(DCI_ADDR_IRQ_ENABLE_SET, 32'h0);
    wr(DCI_ADDR_IRQ_ENABLE_CLEAR, 32'h0);
    wr(DCI_ADDR_IRQ_ENABLE_SET, 32'h0000_0001, DCI_RESP_OKAY, 4'hE); // Lane 0 off: no change
    wr(DCI_ADDR_IRQ_ENABLED_VIEW, 32'hFF); // Read-only view ignores writes
    rd("mask_part", DCI_ADDR_IRQ_ENABLED_VIEW, 32'h72);
    $display("Test mask done");
    // Each source in turn: set, hold, refuse zero clears, clear
    for (int k = 0; k < 6; k++) begin
      pos = (k < 3) ? k : k + 1;
      bit_v = 32'h1 << pos;
      eng.fire(k, k % 2 + 1);
      repeat (3) @(posedge mclk);
      chk("irq_req", (32'h72 >> pos) & 32'h1, {31'h0, irq_req});
      wr(DCI_ADDR_IRQ_ACKNOWLEDGE, ~bit_v);
      rd("pend_set", DCI_ADDR_IRQ_PENDING_VIEW, bit_v);
      wr(DCI_ADDR_IRQ_ACKNOWLEDGE, bit_v);
      rd("pend_clr", DCI_ADDR_IRQ_PENDING_VIEW, 32'h0);
      chk("irq_off", 32'h0, {31'h0, irq_req});
    end
    $display("Test sources done");
    wr(DCI_ADDR_CONTRAST_CMP, 32'h0000_01A5);
    rd("cmp", DCI_ADDR_CONTRAST_CMP, 32'hA5);
    wr(DCI_ADDR_CONTRAST_CMP, 32'h40);
    // Every polarity and prescale: active run is 64 counts, idle run 192
    for (int p = 0; p < 8; p++) begin
      wr(DCI_ADDR_CONTRAST_CTRL, 32'h8 | p);
      n = 0;
      run = 0;
      while (contrast_pwm !== !p[2]) tick(n);
      while (contrast_pwm !== p[2]) tick(n);
      while (contrast_pwm === p[2]) begin
        tick(n);
        run++;
      end
      chk("pwm_run_len", 32'h40 << p[1:0], run);
    end
    // Stopped generator holds its output
    wr(DCI_ADDR_CONTRAST_CTRL, 32'h4);
    rd("ctrl", DCI_ADDR_CONTRAST_CTRL, 32'h4);
    repeat (2) @(posedge mclk);
    v = contrast_pwm;
    chg = 0;
    repeat (300) begin
      @(posedge mclk);
      chg += (contrast_pwm !== v);
    end
    chk("pwm_changes", 32'h0, chg);
    $display("Test contrast done");
    rd("unmapped", 32'h0050_0900, 32'h0, DCI_RESP_SLVERR);
    wr(32'h0050_0900, 32'h1, DCI_RESP_SLVERR);
    rd("wo_reg", DCI_ADDR_IRQ_ACKNOWLEDGE, 32'h0);
    $display("Test bus_errors done");
    tally_and_finish();
  end
endmodule : tb_top
